// ===== inc/sas_consts.svh
// Constants for the successive-approximation converter sequencer
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH
`define SAS_NUM_CH          8
`define SAS_RES_BITS        8
`define SAS_CH_SEL_BITS     5
`define SAS_CH_OFF          5'h1F
`define SAS_CH_EXT_MAX      5'h07
`define SAS_CONV_CYCLES     5'h10
`define SAS_DIV_BITS        3
`define SAS_DIV_CNT_BITS    4
`define SAS_CODE_FULL       8'hFF
`define SAS_CODE_ZERO       8'h00
`define SAS_MSB_BIT         8'h80
`endif

// ===== inc/sas_pkg.sv
// Types shared by the converter sequencer
package sas_pkg;
	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_CONV,
		SAS_DONE
	} sas_state_t;
endpackage

// ===== hdl/sas_sequencer.sv
// Converter sequencer: channel mux, port override, SAR control, flags
// Behaviour
// [RQ1] Selected shared pin forced as converter input
// [RQ2] Port writes ignored on the selected pin
// [RQ3] Port read of selected pin returns zero
// [RQ4] High reference gives FF, low gives 00
// [RQ5] Control register write starts a conversion
// [RQ6] Conversion takes 16 to 17 converter clocks
// [RQ7] Software sets converter clock near one megahertz
// [RQ8] Continuous mode overwrites result every conversion
// [RQ9] Continuous conversions repeat until bit cleared
// [RQ10] Continuous done flag holds until write/read
// [RQ11] Single mode: one conversion per write
// [RQ12] Interrupt enabled: interrupt, not done flag
// [RQ13] Done bit zero while interrupt asserted
// [RQ14] Converter keeps running during wait mode
// [RQ15] Software powers down before wait if unneeded
// [RQ16] Stop aborts conversion; resumes after stop
// [RQ17] Eight-bit results from eight channels
// [RQ18] Data read or control write removes interrupt
// [RQ19] Five-bit select: eight inputs or references
// [RQ20] All-ones select turns converter off
// [RQ21] Divider 1,2,4,8, or 16 with top bit
// [RQ22] Write mid-conversion restarts on new channel
`timescale 1ns/10ps
`default_nettype none
`include "sas_consts.svh"
module sas_sequencer
	import sas_pkg::*;
#(
	parameter int NUM_CH = `SAS_NUM_CH
) (
	// Clock and reset
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST,
	// Control register write strobe and fields
	input  wire logic                          I_CTRL_WR,
	input  wire logic [`SAS_CH_SEL_BITS-1:0]   I_INPUT_CHANNEL_SELECT,
	input  wire logic                          I_CONTINUOUS_CONV_BIT,
	input  wire logic                          I_CONV_IRQ_ENABLE,
	// Clock register fields and clock sources
	input  wire logic [`SAS_DIV_BITS-1:0]      I_CONV_CLOCK_DIVIDER,
	input  wire logic                          I_CONV_CLOCK_SOURCE_SELECT,
	input  wire logic                          I_EXT_CLK_TICK,
	// Data register read strobe
	input  wire logic                          I_DATA_RD,
	// Low-power mode
	input  wire logic                          I_STOP_MODE,
	// Port logic side of the shared pins
	input  wire logic [NUM_CH-1:0]             I_PORT_OUT,
	input  wire logic [NUM_CH-1:0]             I_PORT_DIR,
	input  wire logic [NUM_CH-1:0]             I_PIN_IN,
	output logic      [NUM_CH-1:0]             O_PIN_OUT,
	output logic      [NUM_CH-1:0]             O_PIN_OE_N,
	output logic      [NUM_CH-1:0]             O_PORT_RD,
	output logic      [NUM_CH-1:0]             O_ANALOG_SEL,
	// Analog comparator interface
	input  wire logic                          I_CMP_ABOVE,
	output logic [`SAS_RES_BITS-1:0]           O_DAC_CODE,
	output logic                               O_CONV_ACTIVE,
	// Status and result
	output logic [`SAS_RES_BITS-1:0]           O_DATA,
	output logic                               O_CONV_DONE_FLAG,
	output logic                               O_CONV_IRQ,
	output logic                               O_CONV_POWERED
);

	// Synchronised pin and comparator inputs
	logic [NUM_CH-1:0] pin_s1_ff, pin_s2_ff;
	logic              cmp_s1_ff, cmp_s2_ff, xt_s1_ff, xt_s2_ff, xt_d_ff;
	// Sequencer state
	sas_state_t        state_ff;
	logic [`SAS_CH_SEL_BITS-1:0] ch_ff;     // Latched channel
	logic              cont_ff, ien_ff;     // Latched mode bits
	logic [`SAS_DIV_CNT_BITS-1:0] div_ff;   // Clock prescaler
	logic [4:0]        cyc_ff;              // Converter clocks in conversion
	logic [`SAS_RES_BITS-1:0] sar_ff, bit_ff, data_ff;
	logic              done_ff, irq_ff, first_ff;
	logic              src_tick, adc_tick, powered, last_cyc, conv_end;
	logic              lead_ff, step_tick;  // Partial first external tick, and ticks that count
	logic [`SAS_DIV_CNT_BITS-1:0] div_max;

	// Two-flop synchronisers; first stage read only by the second
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			cmp_s1_ff <= 1'b0;
			cmp_s2_ff <= 1'b0;
			xt_s1_ff  <= 1'b0;
			xt_s2_ff  <= 1'b0;
			xt_d_ff   <= 1'b0;
		end else begin
			pin_s1_ff <= I_PIN_IN;
			pin_s2_ff <= pin_s1_ff;
			cmp_s1_ff <= I_CMP_ABOVE;
			cmp_s2_ff <= cmp_s1_ff;
			xt_s1_ff  <= I_EXT_CLK_TICK;
			xt_s2_ff  <= xt_s1_ff;
			xt_d_ff   <= xt_s2_ff;
		end
	end

	// Pin mux: selected channel taken away from port logic
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_pin
			logic sel;
			assign sel = powered && (ch_ff == 5'(g));
			assign O_ANALOG_SEL[g] = sel;                          // RQ1
			assign O_PIN_OE_N[g]   = sel ? 1'b1 : ~I_PORT_DIR[g];  // RQ1 RQ2
			assign O_PIN_OUT[g]    = sel ? 1'b0 : I_PORT_OUT[g];   // RQ2
			assign O_PORT_RD[g]    = sel ? 1'b0 : pin_s2_ff[g];    // RQ3
		end
	endgenerate

	// Off code powers down; reference codes leave no pin selected
	assign powered        = (ch_ff != `SAS_CH_OFF);                // RQ19 RQ20
	assign O_CONV_POWERED = powered;
	// Input clock: bus clock, or edge of synchronised external clock
	assign src_tick = I_CONV_CLOCK_SOURCE_SELECT ? 1'b1 : (xt_s2_ff & ~xt_d_ff);
	// Divide by 1,2,4,8, or 16 when top bit set
	always_comb begin
		case (I_CONV_CLOCK_DIVIDER[1:0])                           // RQ21
			2'h0:    div_max = 4'h0;
			2'h1:    div_max = 4'h1;
			2'h2:    div_max = 4'h3;
			default: div_max = 4'h7;
		endcase
		if (I_CONV_CLOCK_DIVIDER[2])
			div_max = 4'hF;                                        // RQ21
	end
	assign adc_tick = src_tick && (div_ff >= div_max);

	// Prescaler counter, restarted by each control write
	always_ff @(posedge I_CLK) begin
		if (I_RST || I_CTRL_WR || I_STOP_MODE)
			div_ff <= '0;
		else if (src_tick)
			div_ff <= adc_tick ? '0 : div_ff + 4'h1;
	end

	// External ticks run free, so the first one after a start or a stop is a
	// partial converter clock; skipping it keeps conversions at 16 to 17 clocks
	always_ff @(posedge I_CLK) begin
		if (I_RST)
			lead_ff <= 1'b0;
		else if (I_CTRL_WR || I_STOP_MODE)
			lead_ff <= ~I_CONV_CLOCK_SOURCE_SELECT;                // RQ6
		else if (adc_tick)
			lead_ff <= 1'b0;
	end
	assign step_tick = adc_tick && !lead_ff;

	// Control register image, latched on write
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ch_ff   <= `SAS_CH_OFF;
			cont_ff <= 1'b0;
			ien_ff  <= 1'b0;
		end else if (I_CTRL_WR) begin
			ch_ff   <= I_INPUT_CHANNEL_SELECT;
			cont_ff <= I_CONTINUOUS_CONV_BIT;                      // RQ9
			ien_ff  <= I_CONV_IRQ_ENABLE;
		end
	end

	// Last of 16 converter clocks; trial bits on clocks 0 to 7
	assign last_cyc = (cyc_ff == `SAS_CONV_CYCLES - 5'h1);
	assign conv_end = (state_ff == SAS_CONV) && step_tick && last_cyc && !I_STOP_MODE;

	// Sequencer; runs through wait mode, aborted by stop
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			state_ff <= SAS_IDLE;
			cyc_ff   <= '0;
		end else if (I_CTRL_WR) begin
			state_ff <= (I_INPUT_CHANNEL_SELECT != `SAS_CH_OFF)
				? SAS_CONV : SAS_IDLE;                             // RQ5 RQ22
			cyc_ff   <= '0;
		end else if (!powered) begin
			state_ff <= SAS_IDLE;                                  // RQ20
		end else if (I_STOP_MODE) begin
			cyc_ff   <= '0;                                        // RQ16
			if (state_ff == SAS_CONV || cont_ff)
				state_ff <= SAS_CONV;                              // RQ16
			else
				state_ff <= SAS_IDLE;
		end else begin
			case (state_ff)
				SAS_IDLE: state_ff <= SAS_IDLE;                    // RQ11
				SAS_CONV: begin
					if (step_tick) begin
						cyc_ff <= last_cyc ? '0 : cyc_ff + 5'h1;   // RQ6
						if (last_cyc)
							state_ff <= cont_ff ? SAS_CONV : SAS_DONE; // RQ9 RQ11
					end
				end
				SAS_DONE: state_ff <= SAS_IDLE;
				default:  state_ff <= SAS_IDLE;
			endcase
		end
	end

	// Successive approximation: one bit per converter clock on clocks 0 to 7
	// Comparator lags two flops: a converter clock needs three bus clocks at least
	always_ff @(posedge I_CLK) begin
		if (I_RST || I_CTRL_WR || I_STOP_MODE || (state_ff != SAS_CONV)) begin
			sar_ff <= `SAS_MSB_BIT;
			bit_ff <= `SAS_MSB_BIT;
		end else if (step_tick && last_cyc) begin
			sar_ff <= `SAS_MSB_BIT;
			bit_ff <= `SAS_MSB_BIT;
		end else if (step_tick && bit_ff != `SAS_CODE_ZERO) begin
			// Keep the trial bit when input is above the trial level
			sar_ff <= (cmp_s2_ff ? sar_ff : (sar_ff & ~bit_ff)) | (bit_ff >> 1); // RQ4
			bit_ff <= bit_ff >> 1;
		end
	end
	assign O_DAC_CODE    = sar_ff;
	assign O_CONV_ACTIVE = (state_ff == SAS_CONV) && !I_STOP_MODE;

	// Result load on every completion, read or not
	always_ff @(posedge I_CLK) begin
		if (I_RST)
			data_ff <= `SAS_CODE_ZERO;
		else if (conv_end)
			data_ff <= sar_ff;                                     // RQ8 RQ17
	end
	assign O_DATA = data_ff;

	// Done flag and interrupt; completion wins over same-cycle clear
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			done_ff  <= 1'b0;
			irq_ff   <= 1'b0;
			first_ff <= 1'b0;
		end else begin
			if (I_CTRL_WR)
				first_ff <= 1'b1;
			else if (conv_end)
				first_ff <= 1'b0;
			if (conv_end && ien_ff)
				irq_ff <= 1'b1;                                    // RQ12 RQ14
			else if (I_CTRL_WR || I_DATA_RD)
				irq_ff <= 1'b0;                                    // RQ18
			if (conv_end && !ien_ff && (!cont_ff || first_ff))
				done_ff <= 1'b1;                                   // RQ10
			else if (I_CTRL_WR || I_DATA_RD || ien_ff)
				done_ff <= 1'b0;                                   // RQ10 RQ13
		end
	end
	assign O_CONV_DONE_FLAG = done_ff;
	assign O_CONV_IRQ       = irq_ff;

	// Checks
	property p_sel_rd_zero;
		@(posedge I_CLK) disable iff (I_RST)
		powered && ch_ff <= `SAS_CH_EXT_MAX |-> O_PORT_RD[ch_ff[2:0]] == 1'b0;
	endproperty
	a_sel_rd_zero: assert property (p_sel_rd_zero) else $error("selected pin read not zero"); // RQ3
	property p_sel_oe;
		@(posedge I_CLK) disable iff (I_RST)
		powered && ch_ff <= `SAS_CH_EXT_MAX |-> O_PIN_OE_N[ch_ff[2:0]] && O_ANALOG_SEL[ch_ff[2:0]];
	endproperty
	a_sel_oe: assert property (p_sel_oe) else $error("selected pin still driven"); // RQ1
	property p_start;
		@(posedge I_CLK) disable iff (I_RST)
		I_CTRL_WR && I_INPUT_CHANNEL_SELECT != `SAS_CH_OFF |=> state_ff == SAS_CONV && cyc_ff == 5'h0;
	endproperty
	a_start: assert property (p_start) else $error("write did not start conversion"); // RQ5
	property p_data_load;
		@(posedge I_CLK) disable iff (I_RST)
		conv_end |=> O_DATA == $past(sar_ff);
	endproperty
	a_data_load: assert property (p_data_load) else $error("result not loaded"); // RQ8
	property p_irq_clr;
		@(posedge I_CLK) disable iff (I_RST)
		(I_DATA_RD || I_CTRL_WR) && !conv_end |=> !O_CONV_IRQ;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt not removed"); // RQ18
	property p_done_low_ien;
		@(posedge I_CLK) disable iff (I_RST)
		O_CONV_IRQ && ien_ff && !$rose(ien_ff) |-> !O_CONV_DONE_FLAG;
	endproperty
	a_done_low_ien: assert property (p_done_low_ien) else $error("done set with interrupt"); // RQ13
	property p_single_idle;
		@(posedge I_CLK) disable iff (I_RST)
		conv_end && !cont_ff && !I_CTRL_WR ##1 !I_CTRL_WR |-> state_ff == SAS_DONE ##1 state_ff == SAS_IDLE;
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("single mode did not stop"); // RQ11
	property p_cont_go;
		@(posedge I_CLK) disable iff (I_RST)
		conv_end && cont_ff && !I_CTRL_WR && !I_STOP_MODE |=> state_ff == SAS_CONV;
	endproperty
	a_cont_go: assert property (p_cont_go) else $error("continuous mode stopped"); // RQ9
	property p_off;
		@(posedge I_CLK) disable iff (I_RST)
		!powered && !I_CTRL_WR |=> state_ff == SAS_IDLE && O_ANALOG_SEL == '0;
	endproperty
	a_off: assert property (p_off) else $error("converter active while off"); // RQ20
	property p_stop_abort;
		@(posedge I_CLK) disable iff (I_RST)
		I_STOP_MODE && powered |=> cyc_ff == 5'h0 && $stable(O_DATA);
	endproperty
	a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort conversion"); // RQ16
	c_single: cover property (@(posedge I_CLK) disable iff (I_RST) conv_end && !cont_ff);
	c_cont:   cover property (@(posedge I_CLK) disable iff (I_RST) conv_end && cont_ff);
	c_irq:    cover property (@(posedge I_CLK) disable iff (I_RST) $rose(O_CONV_IRQ));
	c_stop:   cover property (@(posedge I_CLK) disable iff (I_RST) I_STOP_MODE && state_ff == SAS_CONV);

endmodule // sas_sequencer
`default_nettype wire

// ===== tb/sas_analog_src.sv
// Analog sources on the shared pins and the comparator
`timescale 1ns/10ps
`default_nettype none
module sas_analog_src (
	// Source levels and converter view
	input  wire logic [63:0] i_levels,
	input  wire logic [7:0]  i_sel,
	input  wire logic [7:0]  i_code,
	// Pin drive from the port side
	input  wire logic [7:0]  i_pin_out,
	input  wire logic [7:0]  i_oe_n,
	// Comparator and pin levels
	output logic             o_above,
	output logic [7:0]       o_pin_in
);
	logic [7:0] vin; // Level of the chosen source
	// Mux of the source levels
	always_comb begin
		vin = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i_sel[i]) vin = i_levels[i*8+:8];
		end
	end
	// Bit kept once input reaches trial, so full scale gives FF
	assign o_above = (vin >= i_code);
	// Released pins show a fixed pattern, never a stale value
	assign o_pin_in = (~i_oe_n & i_pin_out) | (i_oe_n & 8'hC7);
endmodule // sas_analog_src
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic       clk, rst, wr, cont, ien, src, ext, rd, stop, above;
	logic [4:0] sel;     // Channel field
	logic [2:0] div;     // Divider field
	logic [7:0] pout, pdir, pin, po, oe_n, prd, asel, code, data;
	logic       act, done, irq, pwr;
	logic [63:0] levels; // Source levels, channel 0 lowest
	int         err_total, checked;
	sas_sequencer u_dut (.I_CLK(clk), .I_RST(rst), .I_CTRL_WR(wr), .I_INPUT_CHANNEL_SELECT(sel),
		.I_CONTINUOUS_CONV_BIT(cont), .I_CONV_IRQ_ENABLE(ien), .I_CONV_CLOCK_DIVIDER(div),
		.I_CONV_CLOCK_SOURCE_SELECT(src), .I_EXT_CLK_TICK(ext), .I_DATA_RD(rd), .I_STOP_MODE(stop),
		.I_PORT_OUT(pout), .I_PORT_DIR(pdir), .I_PIN_IN(pin), .O_PIN_OUT(po), .O_PIN_OE_N(oe_n),
		.O_PORT_RD(prd), .O_ANALOG_SEL(asel), .I_CMP_ABOVE(above), .O_DAC_CODE(code),
		.O_CONV_ACTIVE(act), .O_DATA(data), .O_CONV_DONE_FLAG(done), .O_CONV_IRQ(irq), .O_CONV_POWERED(pwr));
	sas_analog_src u_src (.i_levels(levels), .i_sel(asel), .i_code(code), .i_pin_out(po),
		.i_oe_n(oe_n), .o_above(above), .o_pin_in(pin));
	// Bus clock and a free-running slower external clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		ext = 1'b0;
		forever #40 ext = ~ext;
	end
	function automatic logic [7:0] lvl(input int c);
		return levels[c*8+:8];
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic results();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Control write: fields held for the one taking edge
	task automatic wr_ctl(input logic [4:0] s, input logic c, input logic e);
		@(negedge clk);
		sel = s;
		cont = c;
		ien = e;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_data();
		@(negedge clk);
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
	endtask
	// Bounded wait for done or interrupt
	task automatic wait_flag(input int lim, output int n);
		n = 0;
		while (done !== 1'b1 && irq !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				chk(8'h00, 8'h01, "flag timeout");
				results();
			end
		end
	endtask
	task automatic t_pins();
		int n;
		pout = 8'hAA;
		pdir = 8'hFF;
		wr_ctl(5'h02, 1'b0, 1'b0);
		chk(asel, 8'h04, "analog select");
		chk(oe_n, 8'h04, "pin release");
		chk(po & 8'hFB, 8'hAA, "port drive");
		pout = 8'h55;
		pdir = 8'h00;
		repeat (4) @(negedge clk);
		chk(oe_n, 8'hFF, "direction write");
		chk(po, 8'h51, "port write ignored");
		chk(prd, 8'hC3, "port read");
		wait_flag(400, n);
		rd_data();
		$display("test pins done");
	endtask
	task automatic t_value();
		int n;
		for (int c = 0; c < 8; c++) begin
			wr_ctl(5'(c), 1'b0, 1'b0);
			wait_flag(400, n);
			chk(data, lvl(c), "result");
			rd_data();
			repeat (200) @(negedge clk);
			chk({act, done}, 8'h00, "single conversion");
		end
		$display("test values done");
	endtask
	// Codes 0..4, 7, then external source undivided
	task automatic t_div();
		int n, d;
		for (int k = 0; k < 7; k++) begin
			div = (k == 5) ? 3'h7 : (k == 6) ? 3'h0 : 3'(k);
			src = (k != 6);
			d = (k == 5) ? 16 : (k == 6) ? 4 : (1 << k);
			wr_ctl(5'h00, 1'b0, 1'b0);
			wait_flag(600, n);
			chk({7'h00, n >= 16*d-2 && n <= 17*d+4}, 8'h01, "conversion time");
			rd_data();
		end
		div = 3'h3;
		src = 1'b1;
		$display("test divider done");
	endtask
	task automatic t_cont();
		int n;
		wr_ctl(5'h00, 1'b1, 1'b0);
		wait_flag(400, n);
		chk(data, 8'hFF, "first result");
		levels[7:0] = 8'h42;
		repeat (300) @(negedge clk);
		chk(data, 8'h42, "overwritten result");
		chk({7'h00, done}, 8'h01, "done holds");
		rd_data();
		chk({7'h00, done}, 8'h00, "read clears done");
		wr_ctl(5'h00, 1'b0, 1'b0);
		wait_flag(400, n);
		rd_data();
		repeat (300) @(negedge clk);
		chk({act, done}, 8'h00, "continuous stops");
		levels[7:0] = 8'hFF;
		$display("test continuous done");
	endtask
	task automatic t_irq();
		int n;
		wr_ctl(5'h02, 1'b0, 1'b1);
		wait_flag(400, n);
		chk({irq, done}, 8'h02, "interrupt not flag");
		rd_data();
		chk({7'h00, irq}, 8'h00, "read clears irq");
		wr_ctl(5'h02, 1'b0, 1'b1);
		wait_flag(400, n);
		wr_ctl(5'h1F, 1'b0, 1'b0);
		chk({irq, pwr}, 8'h00, "write clears irq, off");
		repeat (300) @(negedge clk);
		chk({act, done}, 8'h00, "off stays idle");
		wr_ctl(5'h1D, 1'b0, 1'b0);
		chk({asel[6:0], pwr}, 8'h01, "reference input");
		wait_flag(400, n);
		rd_data();
		$display("test interrupt done");
	endtask
	task automatic t_stop();
		int n;
		wr_ctl(5'h03, 1'b0, 1'b0);
		repeat (40) @(negedge clk);
		stop = 1'b1;
		repeat (300) @(negedge clk);
		chk({7'h00, done}, 8'h00, "stop aborts");
		stop = 1'b0;
		wait_flag(400, n);
		chk(data, lvl(3), "resumed result");
		rd_data();
		wr_ctl(5'h04, 1'b0, 1'b0);
		repeat (50) @(negedge clk);
		wr_ctl(5'h05, 1'b0, 1'b0);
		wait_flag(400, n);
		chk(data, lvl(5), "restart new channel");
		rd_data();
		repeat (200) @(negedge clk);
		chk({7'h00, done}, 8'h00, "one result only");
		$display("test stop done");
	endtask
	// Main sequence: inputs at time zero, reset, scenarios
	initial begin
		{rst, wr, cont, ien, rd, stop} = 6'h20;
		src = 1'b1;
		div = 3'h3;
		sel = 5'h1F;
		pout = 8'h00;
		pdir = 8'h00;
		levels = {8'h81, 8'h3C, 8'h01, 8'hFE, 8'h7F, 8'h5A, 8'h00, 8'hFF};
		err_total = 0;
		checked = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_pins();
		t_value();
		t_div();
		t_cont();
		t_irq();
		t_stop();
		results();
	end
endmodule // testbench
`default_nettype wire
